// ==== hdl/etx_top.sv ====
// Transmit descriptor DMA and MII transmitter of an Ethernet controller
// Assumes a word memory with held request and one-cycle ack, a free
// running PHY transmit clock, and software levels on clock_in
//
// Contract
// R1: Enable bit moves MAC to idle
// R2: Half duplex: wait no carrier, gap, preamble
// R3: Full duplex: preamble at once on request
// R4: Full duplex back to back: one gap
// R5: Preamble, delimiter, data, CRC, then done event
// R6: Separate collision and carrier lost events
// R7: After frame back to idle, continue
// R8: Memory read in 16-byte blocks
// R9: Start on kick only with enable set
// R10: After reset start at list base
// R11: Step descriptors by selected size
// R12: Three words: flags, length, address
// R13: Padding words never read
// R14: Owned descriptor: read buffer, feed MAC
// R15: Continuing buffer: clear owner, next
// R16: Frame end: wait sent, write back
// R17: Result into 26-bit status field
// R18: Unowned descriptor: clear kick, stop
// R19: Next kick resumes after last sent
// R20: Software presets position and zero flags
// R21: Last flag wraps to list base
// R22: Software fills length, address first
// R23: Nibbles on PHY clock, enable framing
`timescale 1ns/10ps
`include "etx_params.svh"
module etx_top (
   // System clock and software reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // Software control and status
   input  wire logic        tx_enable_bit_in,
   input  wire logic        full_duplex_in,
   input  wire logic        tx_kick_in,
   input  wire logic [31:0] tx_list_base_reg_in,
   input  wire logic        desc_size_low_in,
   input  wire logic        desc_size_high_in,
   output logic             tx_kick_bit_out,
   output logic             tx_done_irq_out,
   output logic             col_irq_out,
   output logic             crs_lost_irq_out,
   // Memory master
   output logic             mem_req_out,
   output logic             mem_we_out,
   output logic [31:0]      mem_addr_out,
   output logic [31:0]      mem_wdata_out,
   input  wire logic [31:0] mem_rdata_in,
   input  wire logic        mem_ack_in,
   // MII transmit side
   input  wire logic        tx_clk_in,
   input  wire logic        mii_crs_in,
   input  wire logic        mii_col_in,
   output logic [3:0]       mii_txd_out,
   output logic             mii_tx_en_out
);
   import etx_pkg::*;

   //------------------------------------------------------------
   // System domain: descriptor DMA
   //------------------------------------------------------------
   etx_dma_st_t st_ff;
   logic        run_ff, first_ff, req_tgl_ff;
   logic [31:0] cur_ff, w0_ff, bptr_ff, dsz;
   logic [15:0] rem_ff;
   logic [2:0]  bcnt_ff, bidx_ff;
   logic [31:0] blk_ff [`ETX_BLK_WORDS];
   etx_word_t   hw_ff;
   logic        mem_req_ff, mem_we_ff;
   logic [31:0] mem_addr_ff, mem_wdata_ff;
   logic        ack_s, done_s, done_seen_ff, done_pend_ff;
   etx_stat_t   res_ff, lnk_stat_ff;
   logic        irq_done_ff, irq_col_ff, irq_crs_ff;
   logic        kick_ok, hand_free;
   logic        ack_tgl_ff, done_tgl_ff;

   // Descriptor stride; padding beyond word two is skipped
   assign dsz = `ETX_DSZ_MIN << {desc_size_high_in, desc_size_low_in}; // [R11] [R13]
   assign kick_ok = tx_kick_in & tx_enable_bit_in & ~run_ff; // [R9]
   assign hand_free = (ack_s == req_tgl_ff);

   // Return toggles from the link side
   etx_sync #(.W(2)) u_sync_sys (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .d_in     ({ack_tgl_ff, done_tgl_ff}),
      .q_out    ({ack_s, done_s})
   );

   // Descriptor walk, memory requests and word hand-off
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         st_ff        <= D_IDLE;
         run_ff       <= 1'b0;
         first_ff     <= 1'b1;
         cur_ff       <= `ETX_BASE_RST;
         w0_ff        <= '0;
         rem_ff       <= '0;
         bptr_ff      <= '0;
         bcnt_ff      <= '0;
         bidx_ff      <= '0;
         hw_ff        <= '0;
         req_tgl_ff   <= 1'b0;
         mem_req_ff   <= 1'b0;
         mem_we_ff    <= 1'b0;
         mem_addr_ff  <= '0;
         mem_wdata_ff <= '0;
      end else begin
         if (mem_ack_in) begin
            mem_req_ff <= 1'b0;
         end
         case (st_ff)
            D_IDLE: if (kick_ok) begin
               run_ff <= 1'b1;
               if (first_ff) begin
                  cur_ff   <= tx_list_base_reg_in; // [R10]
                  first_ff <= 1'b0;
               end // else resume at cur_ff [R19]
               st_ff <= D_RD0;
            end
            D_RD0: if (!mem_req_ff) begin
               mem_req_ff  <= 1'b1;
               mem_we_ff   <= 1'b0;
               mem_addr_ff <= cur_ff;
            end else if (mem_ack_in) begin
               w0_ff <= mem_rdata_in; // [R12]
               if (mem_rdata_in[`ETX_OWN_BIT]) begin
                  st_ff <= D_RD1;
               end else begin
                  run_ff <= 1'b0; // [R18]
                  st_ff  <= D_IDLE;
               end
            end
            D_RD1: if (!mem_req_ff) begin
               mem_req_ff  <= 1'b1;
               mem_addr_ff <= cur_ff + `ETX_W1_OFS;
            end else if (mem_ack_in) begin
               rem_ff <= mem_rdata_in[15:0]; // [R12]
               st_ff  <= D_RD2;
            end
            D_RD2: if (!mem_req_ff) begin
               mem_req_ff  <= 1'b1;
               mem_addr_ff <= cur_ff + `ETX_W2_OFS;
            end else if (mem_ack_in) begin
               bptr_ff <= mem_rdata_in; // [R12] [R14]
               bcnt_ff <= '0;
               st_ff   <= (rem_ff == 16'h0) ? D_WB : D_FETCH;
            end
            D_FETCH: if (!mem_req_ff) begin
               mem_req_ff  <= 1'b1;
               mem_addr_ff <= bptr_ff; // [R14]
            end else if (mem_ack_in) begin
               blk_ff[bcnt_ff[1:0]] <= mem_rdata_in;
               bcnt_ff <= bcnt_ff + 3'h1;
               bptr_ff <= bptr_ff + `ETX_WORD_B;
               // Block ends at four words or end of buffer
               if (bcnt_ff == 3'h3 ||
                   {11'h0, bcnt_ff + 3'h1, 2'b00} >= rem_ff) begin // [R8]
                  bidx_ff <= '0;
                  st_ff   <= D_PUSH;
               end
            end
            D_PUSH: if (hand_free) begin
               hw_ff.data <= blk_ff[bidx_ff[1:0]];
               hw_ff.nbm1 <= (rem_ff >= 16'h4) ? 2'h3 : 2'(rem_ff - 16'h1);
               hw_ff.eof  <= (rem_ff <= 16'h4) & w0_ff[`ETX_FP_LO]; // [R20]
               rem_ff     <= (rem_ff >= 16'h4) ? rem_ff - 16'h4 : 16'h0;
               req_tgl_ff <= ~req_tgl_ff;
               bidx_ff    <= bidx_ff + 3'h1;
               if (rem_ff <= 16'h4) begin
                  st_ff <= w0_ff[`ETX_FP_LO] ? D_WAIT : D_WB; // [R15] [R16]
               end else if (bidx_ff + 3'h1 == bcnt_ff) begin
                  bcnt_ff <= '0;
                  st_ff   <= D_FETCH;
               end
            end
            D_WAIT: if (done_pend_ff) begin
               st_ff <= D_WB; // [R16]
            end
            D_WB: if (!mem_req_ff) begin
               mem_req_ff  <= 1'b1;
               mem_we_ff   <= 1'b1;
               mem_addr_ff <= cur_ff;
               if (w0_ff[`ETX_FP_LO]) begin
                  mem_wdata_ff <= {1'b0, w0_ff[30:28], |res_ff,
                                   w0_ff[`ETX_WBI_BIT], 23'h0, res_ff}; // [R17]
               end else begin
                  mem_wdata_ff <= {1'b0, w0_ff[30:0]}; // [R15]
               end
            end else if (mem_ack_in) begin
               mem_we_ff <= 1'b0;
               if (w0_ff[`ETX_LAST_BIT]) begin
                  cur_ff <= tx_list_base_reg_in; // [R21]
               end else begin
                  cur_ff <= cur_ff + dsz; // [R11]
               end
               st_ff <= D_RD0;
            end
            default: st_ff <= D_IDLE;
         endcase
      end
   end

   // Frame results from the link; set wins over consume
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         done_seen_ff <= 1'b0;
         done_pend_ff <= 1'b0;
         res_ff       <= '0;
         irq_done_ff  <= 1'b0;
         irq_col_ff   <= 1'b0;
         irq_crs_ff   <= 1'b0;
      end else begin
         irq_done_ff <= 1'b0;
         irq_col_ff  <= 1'b0;
         irq_crs_ff  <= 1'b0;
         if (st_ff == D_WAIT) begin
            done_pend_ff <= 1'b0;
         end
         if (done_s != done_seen_ff) begin
            done_seen_ff <= done_s;
            done_pend_ff <= 1'b1;
            res_ff       <= lnk_stat_ff;
            irq_done_ff  <= 1'b1; // [R5]
            irq_col_ff   <= lnk_stat_ff.col; // [R6]
            irq_crs_ff   <= lnk_stat_ff.crs_lost; // [R6]
         end
      end
   end

   assign tx_kick_bit_out  = run_ff;
   assign tx_done_irq_out  = irq_done_ff;
   assign col_irq_out      = irq_col_ff;
   assign crs_lost_irq_out = irq_crs_ff;
   assign mem_req_out      = mem_req_ff;
   assign mem_we_out       = mem_we_ff;
   assign mem_addr_out     = mem_addr_ff;
   assign mem_wdata_out    = mem_wdata_ff;

   //------------------------------------------------------------
   // Link domain: MAC transmitter on the PHY clock
   //------------------------------------------------------------
   etx_mac_st_t mst_ff;
   logic        lrst, ten_s, fdx_s, crs_s, col_s, req_s;
   logic [4:0]  cnt_ff, gap_ff;
   logic [31:0] sh_ff, crc_ff, crc_nxt;
   logic [2:0]  nib_ff;
   logic        eofc_ff, nxv_ff;
   etx_word_t   nx_ff;
   logic [3:0]  txd_ff;
   logic        txen_ff, mac_ld, sending;

   // Reset into the link domain
   etx_sync #(.W(1)) u_sync_rst (
      .clock_in (tx_clk_in),
      .rst_in   (1'b0),
      .d_in     (rst_in),
      .q_out    (lrst)
   );
   // Controls, PHY pins and request toggle
   etx_sync #(.W(5)) u_sync_lnk (
      .clock_in (tx_clk_in),
      .rst_in   (lrst),
      .d_in     ({tx_enable_bit_in, full_duplex_in, mii_crs_in,
                  mii_col_in, req_tgl_ff}),
      .q_out    ({ten_s, fdx_s, crs_s, col_s, req_s})
   );
   etx_crc u_crc (
      .crc_in  (crc_ff),
      .nib_in  (sh_ff[3:0]),
      .crc_out (crc_nxt)
   );

   assign mac_ld = (mst_ff == M_PRE && cnt_ff == `ETX_PRE_NIB) ||
                   (mst_ff == M_DATA && nib_ff == 3'h0 && !eofc_ff &&
                    nxv_ff);
   assign sending = (mst_ff == M_PRE) || (mst_ff == M_DATA) ||
                    (mst_ff == M_CRC);

   // Next-word slot; hw_ff is held stable until acknowledged
   always_ff @(posedge tx_clk_in) begin
      if (lrst) begin
         nx_ff      <= '0;
         nxv_ff     <= 1'b0;
         ack_tgl_ff <= 1'b0;
      end else if (req_s != ack_tgl_ff && (!nxv_ff || mac_ld)) begin
         nx_ff      <= hw_ff;
         nxv_ff     <= 1'b1;
         ack_tgl_ff <= ~ack_tgl_ff;
      end else if (mac_ld) begin
         nxv_ff <= 1'b0;
      end
   end

   // Transmit sequencer and MII outputs
   always_ff @(posedge tx_clk_in) begin
      if (lrst) begin
         mst_ff      <= M_OFF;
         cnt_ff      <= '0;
         gap_ff      <= `ETX_IFG_NIB;
         sh_ff       <= '0;
         nib_ff      <= '0;
         eofc_ff     <= 1'b0;
         crc_ff      <= `ETX_CRC_INIT;
         txd_ff      <= '0;
         txen_ff     <= 1'b0;
         lnk_stat_ff <= '0;
         done_tgl_ff <= 1'b0;
      end else begin
         if (!sending && gap_ff != `ETX_IFG_NIB) begin
            gap_ff <= gap_ff + 5'h1;
         end
         if (sending && col_s) begin
            lnk_stat_ff.col <= 1'b1; // [R6]
         end
         // Carrier echo lags the enable through the synchroniser,
         // so only data and CRC are judged
         if ((mst_ff == M_DATA || mst_ff == M_CRC) && !fdx_s &&
             !crs_s) begin
            lnk_stat_ff.crs_lost <= 1'b1; // [R6]
         end
         case (mst_ff)
            M_OFF: begin
               txen_ff <= 1'b0;
               txd_ff  <= '0;
               if (ten_s) begin
                  mst_ff <= M_IDLE; // [R1]
               end
            end
            M_IDLE: begin
               txen_ff <= 1'b0;
               txd_ff  <= '0;
               cnt_ff  <= '0;
               if (!ten_s) begin
                  mst_ff <= M_OFF;
               end else if (nxv_ff && !fdx_s) begin
                  mst_ff <= M_CRS; // [R2]
               end else if (nxv_ff && gap_ff == `ETX_IFG_NIB) begin
                  mst_ff      <= M_PRE; // [R3] [R4]
                  lnk_stat_ff <= '0;
               end
            end
            M_CRS: if (!crs_s) begin
               cnt_ff <= '0;
               mst_ff <= M_IFG; // [R2]
            end
            M_IFG: begin
               cnt_ff <= cnt_ff + 5'h1;
               if (crs_s) begin
                  mst_ff <= M_CRS;
               end else if (cnt_ff == `ETX_IFG_NIB - 5'h1) begin
                  cnt_ff      <= '0;
                  mst_ff      <= M_PRE; // [R2]
                  lnk_stat_ff <= '0;
               end
            end
            M_PRE: begin
               txen_ff <= 1'b1; // [R23]
               cnt_ff  <= cnt_ff + 5'h1;
               if (cnt_ff == `ETX_PRE_NIB) begin
                  txd_ff  <= `ETX_SFD_VAL; // [R5]
                  sh_ff   <= nx_ff.data;
                  nib_ff  <= {nx_ff.nbm1, 1'b1};
                  eofc_ff <= nx_ff.eof;
                  crc_ff  <= `ETX_CRC_INIT;
                  mst_ff  <= M_DATA;
               end else begin
                  txd_ff <= `ETX_PRE_VAL;
               end
            end
            M_DATA: begin
               txd_ff <= sh_ff[3:0]; // [R23]
               crc_ff <= crc_nxt;
               sh_ff  <= sh_ff >> 4;
               nib_ff <= nib_ff - 3'h1;
               if (nib_ff == 3'h0) begin
                  if (mac_ld) begin
                     sh_ff   <= nx_ff.data;
                     nib_ff  <= {nx_ff.nbm1, 1'b1};
                     eofc_ff <= nx_ff.eof;
                  end else begin
                     lnk_stat_ff.underrun <= ~eofc_ff;
                     cnt_ff <= '0;
                     mst_ff <= M_CRC; // [R5]
                  end
               end
            end
            M_CRC: begin
               txd_ff <= ~crc_ff[3:0]; // [R5]
               crc_ff <= crc_ff >> 4;
               cnt_ff <= cnt_ff + 5'h1;
               if (cnt_ff == `ETX_CRC_NIB) begin
                  done_tgl_ff <= ~done_tgl_ff; // [R5]
                  gap_ff      <= '0;
                  mst_ff      <= M_IDLE; // [R7]
               end
            end
            default: mst_ff <= M_OFF;
         endcase
      end
   end

   assign mii_txd_out   = txd_ff;
   assign mii_tx_en_out = txen_ff;

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   AST_KICK_EN: assert property (@(posedge clock_in) disable iff (rst_in)
      $rose(run_ff) |-> $past(tx_enable_bit_in) && $past(tx_kick_in)) // [R9]
      else $error("kick bit set without enable");
   AST_BASE: assert property (@(posedge clock_in) disable iff (rst_in)
      (st_ff == D_IDLE && kick_ok && first_ff)
      |=> cur_ff == $past(tx_list_base_reg_in)) // [R10]
      else $error("first descriptor not at list base");
   AST_STOP: assert property (@(posedge clock_in) disable iff (rst_in)
      (st_ff == D_RD0 && mem_req_ff && mem_ack_in &&
       !mem_rdata_in[`ETX_OWN_BIT]) |=> !run_ff && st_ff == D_IDLE) // [R18]
      else $error("unowned descriptor did not stop");
   AST_STEP: assert property (@(posedge clock_in) disable iff (rst_in)
      (st_ff == D_WB && mem_we_ff && mem_ack_in && !w0_ff[`ETX_LAST_BIT])
      |=> cur_ff == $past(cur_ff) + $past(dsz)) // [R11]
      else $error("wrong descriptor stride");
   AST_RING: assert property (@(posedge clock_in) disable iff (rst_in)
      (st_ff == D_WB && mem_we_ff && mem_ack_in && w0_ff[`ETX_LAST_BIT])
      |=> cur_ff == $past(tx_list_base_reg_in)) // [R21]
      else $error("last descriptor did not wrap");
   AST_WB: assert property (@(posedge clock_in) disable iff (rst_in)
      (mem_req_ff && mem_we_ff)
      |-> !mem_wdata_ff[`ETX_OWN_BIT] && mem_addr_ff == cur_ff) // [R15]
      else $error("write back keeps owner or wrong address");
   AST_WAIT: assert property (@(posedge clock_in) disable iff (rst_in)
      (st_ff == D_WAIT && !done_pend_ff) |=> st_ff == D_WAIT) // [R16]
      else $error("write back before frame sent");
   AST_EVT: assert property (@(posedge clock_in) disable iff (rst_in)
      (done_s != done_seen_ff) |=> irq_done_ff &&
      irq_col_ff == $past(lnk_stat_ff.col)) // [R6]
      else $error("frame events not raised");
   AST_FDX: assert property (@(posedge tx_clk_in) disable iff (lrst)
      (mst_ff == M_IDLE && ten_s && fdx_s && nxv_ff &&
       gap_ff == `ETX_IFG_NIB) |=> mst_ff == M_PRE) // [R3]
      else $error("full duplex start delayed");
   AST_DEFER: assert property (@(posedge tx_clk_in) disable iff (lrst)
      (mst_ff == M_IFG && crs_s) |=> mst_ff == M_CRS) // [R2]
      else $error("carrier ignored in gap");
   AST_PRE: assert property (@(posedge tx_clk_in) disable iff (lrst)
      $rose(txen_ff) |-> (txd_ff == `ETX_PRE_VAL)[*8]) // [R23]
      else $error("frame does not open with preamble");
   AST_IDLE: assert property (@(posedge tx_clk_in) disable iff (lrst)
      (mst_ff == M_CRC && cnt_ff == `ETX_CRC_NIB)
      |=> mst_ff == M_IDLE ##1 !txen_ff) // [R7]
      else $error("no return to idle after frame");
   COV_KICK: cover property (@(posedge clock_in) disable iff (rst_in)
      kick_ok && st_ff == D_IDLE);
   COV_RING: cover property (@(posedge clock_in) disable iff (rst_in)
      st_ff == D_WB && mem_ack_in && w0_ff[`ETX_LAST_BIT]);
   COV_COL: cover property (@(posedge clock_in) disable iff (rst_in)
      irq_col_ff);
   COV_B2B: cover property (@(posedge tx_clk_in) disable iff (lrst)
      mst_ff == M_IDLE && nxv_ff && fdx_s && gap_ff != `ETX_IFG_NIB);
endmodule // etx_top

// ==== shared/etx_params.svh ====
// Constants of the transmit descriptor DMA and MAC transmitter
// Definitions only; included by the top and CRC design files of the block
`ifndef ETX_PARAMS_SVH
`define ETX_PARAMS_SVH
// Descriptor word zero field positions
`define ETX_OWN_BIT   31
`define ETX_LAST_BIT  30
`define ETX_FP_HI     29
`define ETX_FP_LO     28
`define ETX_ERR_BIT   27
`define ETX_WBI_BIT   26
`define ETX_STAT_W    26
// Descriptor word offsets and sizes
`define ETX_W1_OFS    32'h4
`define ETX_W2_OFS    32'h8
`define ETX_WORD_B    32'h4
`define ETX_DSZ_MIN   32'h10
`define ETX_BLK_WORDS 4
// Reset values and CRC polynomial
`define ETX_BASE_RST  32'h0
`define ETX_CRC_INIT  32'hffffffff
`define ETX_CRC_POLY  32'hedb88320
// Link timing, in transmit clock nibbles
`define ETX_PRE_NIB   5'h0f
`define ETX_IFG_NIB   5'h18
`define ETX_CRC_NIB   5'h07
`define ETX_PRE_VAL   4'h5
`define ETX_SFD_VAL   4'hd
`endif

// ==== shared/etx_pkg.sv ====
// Types shared by the transmit DMA and MAC transmitter
// No surroundings assumed
package etx_pkg;
   typedef enum logic [2:0] {D_IDLE, D_RD0, D_RD1, D_RD2, D_FETCH,
                             D_PUSH, D_WAIT, D_WB} etx_dma_st_t;
   typedef enum logic [2:0] {M_OFF, M_IDLE, M_CRS, M_IFG, M_PRE,
                             M_DATA, M_CRC} etx_mac_st_t;
   // Word handed from the DMA to the MAC
   typedef struct packed {
      logic [31:0] data;
      logic [1:0]  nbm1;
      logic        eof;
   } etx_word_t;
   // Result of one frame
   typedef struct packed {
      logic underrun;
      logic crs_lost;
      logic col;
   } etx_stat_t;
endpackage

// ==== hdl/etx_sync.sv ====
// Two flip-flop synchroniser for a bundle of levels
// Assumes each bit is a level or a toggle, not a pulse
`timescale 1ns/10ps
module etx_sync #(
   parameter int W = 1
) (
   // Clock and reset of the receiving domain
   input  wire logic         clock_in,
   input  wire logic         rst_in,
   // Levels in and out
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // First stage feeds only the second
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d_in;
         q_ff    <= meta_ff;
      end
   end
   assign q_out = q_ff;
endmodule // etx_sync

// ==== hdl/etx_crc.sv ====
// Ethernet CRC-32 advanced by one nibble, least bit first
// Purely combinational; the caller holds the register
`timescale 1ns/10ps
`include "etx_params.svh"
module etx_crc #(
   parameter logic [31:0] POLY = `ETX_CRC_POLY
) (
   // Running value and nibble
   input  wire logic [31:0] crc_in,
   input  wire logic [3:0]  nib_in,
   output logic      [31:0] crc_out
);
   // Four serial steps of the reflected polynomial
   always_comb begin
      crc_out = crc_in;
      for (int i = 0; i < 4; i++) begin
         if (crc_out[0] ^ nib_in[i]) begin
            crc_out = (crc_out >> 1) ^ POLY;
         end else begin
            crc_out = crc_out >> 1;
         end
      end
   end
endmodule // etx_crc

// ==== test/etx_mem_model.sv ====
// Word memory on the far side of the block's master port
// Assumes requests held until ack; one ack per request
`timescale 1ns/10ps
module etx_mem_model (
   // Clock
   input  wire logic        clock_in,
   // Memory port
   input  wire logic        req_in,
   input  wire logic        we_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        slow_in,
   output logic      [31:0] rdata_out,
   output logic             ack_out
);
   logic [31:0] mem [0:255];
   int          wait_ff = 0;

   initial rdata_out = 32'h0;
   // Ack at once, or after three idle cycles when slow
   always @(posedge clock_in) begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out; // Stale data never looks valid
      if (req_in && !ack_out) begin
         if (slow_in && wait_ff < 3) begin
            wait_ff <= wait_ff + 1;
         end else begin
            ack_out <= 1'b1;
            wait_ff <= 0;
            rdata_out <= mem[addr_in[9:2]];
            if (we_in) mem[addr_in[9:2]] <= wdata_in;
         end
      end
   end
endmodule // etx_mem_model

// ==== test/test_etx_top.sv ====
// Bench of the transmit DMA and MII transmitter
// Assumes etx_mem_model as memory; the PHY is folded in here
`timescale 1ns/10ps
module test_etx_top;
   logic        clock_in = 0, rst_in = 1, tx_clk_in = 0;
   logic        tx_enable_bit_in = 0, full_duplex_in = 1, tx_kick_in = 0;
   logic        desc_size_low_in = 1, desc_size_high_in = 0;
   logic        hold = 0, slow = 0, mii_col_in = 0;
   logic [31:0] tx_list_base_reg_in = 32'h40, mem_rdata_in;
   logic [31:0] mem_addr_out, mem_wdata_out;
   logic        mem_ack_in, mem_req_out, mem_we_out, tx_kick_bit_out;
   logic        tx_done_irq_out, col_irq_out, crs_lost_irq_out;
   logic        mii_tx_en_out, mii_crs_in;
   logic [3:0]  mii_txd_out;
   logic [3:0]  nib [$];
   int          err_total = 0, comparisons = 0, dones = 0;
   int          cols = 0, losts = 0;

   // PHY carrier: forced, or echo of own sending in half duplex
   assign mii_crs_in = hold || (!full_duplex_in && mii_tx_en_out);
   initial forever #50 clock_in = ~clock_in;
   initial begin
      #31;
      forever #62.5 tx_clk_in = ~tx_clk_in;
   end

   etx_top i_dut (.clock_in, .rst_in, .tx_enable_bit_in, .full_duplex_in,
      .tx_kick_in, .tx_list_base_reg_in, .desc_size_low_in,
      .desc_size_high_in, .tx_kick_bit_out, .tx_done_irq_out, .col_irq_out,
      .crs_lost_irq_out, .mem_req_out, .mem_we_out, .mem_addr_out,
      .mem_wdata_out, .mem_rdata_in, .mem_ack_in, .tx_clk_in, .mii_crs_in,
      .mii_col_in, .mii_txd_out, .mii_tx_en_out);
   etx_mem_model i_mem (.clock_in, .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .slow_in(slow),
      .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));

   // Collect nibbles on the wire and count done pulses
   always @(posedge tx_clk_in) if (mii_tx_en_out === 1'b1) nib.push_back(mii_txd_out);
   always @(posedge clock_in) begin
      if (tx_done_irq_out === 1'b1) dones++;
      if (col_irq_out === 1'b1) cols++;
      if (crs_lost_irq_out === 1'b1) losts++;
   end

   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [31:0] a, input logic [31:0] d);
      i_mem.mem[a[9:2]] = d;
   endtask
   task automatic kick();
      @(posedge clock_in) tx_kick_in <= 1'b1;
      @(posedge clock_in) tx_kick_in <= 1'b0;
   endtask
   task automatic wait_idle();
      repeat (2) @(posedge clock_in);
      for (int i = 0; i < 3000 && tx_kick_bit_out !== 1'b0; i++) begin
         @(posedge clock_in);
      end
      chk({31'h0, tx_kick_bit_out}, 32'h0);
   endtask
   // Preamble, delimiter, one word low nibble first, then CRC
   task automatic chk_frame(input logic [31:0] w);
      logic [31:0] crc;
      crc = 32'hffffffff;
      for (int i = 0; i < 32; i++) begin
         crc = (crc[0] ^ w[i]) ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
      end
      crc = ~crc;
      chk(32'(nib.size()), 32'd32);
      for (int i = 0; i < 8; i++) chk(32'(nib[24+i]), 32'(crc[4*i+:4]));
      for (int i = 0; i < 16; i++) chk(32'(nib[i]), (i < 15) ? 32'h5 : 32'hd);
      for (int i = 0; i < 8; i++) chk(32'(nib[16+i]), 32'(w[4*i+:4]));
      nib.delete();
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_full();
      put(32'h40, 32'hb000_0000);
      put(32'h44, 32'h4);
      put(32'h48, 32'h100);
      put(32'h100, 32'h4321_a5c3);
      put(32'h60, 32'h0);
      kick();
      wait_idle();
      chk_frame(32'h4321_a5c3);
      chk(i_mem.mem[8'h10], 32'h3000_0000);
      chk({31'h0, tx_kick_bit_out}, 32'h0);
      chk(32'(dones), 32'd1);
      chk(32'(cols + losts), 32'd0);
      $display("test full duplex frame done");
   endtask
   task automatic t_half_ring();
      put(32'h60, 32'hf000_0000);
      put(32'h64, 32'h4);
      put(32'h68, 32'h104);
      put(32'h104, 32'h0ff1_7e29);
      put(32'h80, 32'hb000_0000);
      full_duplex_in <= 1'b0;
      hold <= 1'b1;
      slow <= 1'b1;
      kick();
      repeat (60) @(posedge clock_in);
      chk({31'h0, mii_tx_en_out}, 32'h0);
      hold <= 1'b0;
      mii_col_in <= 1'b1;
      wait_idle();
      mii_col_in <= 1'b0;
      chk_frame(32'h0ff1_7e29);
      chk(i_mem.mem[8'h18], 32'h7800_0001);
      chk(32'(cols), 32'd1);
      chk(32'(losts), 32'd0);
      chk(i_mem.mem[8'h20], 32'hb000_0000);
      chk(32'(dones), 32'd2);
      $display("test half duplex ring done");
   endtask
   task automatic t_refuse();
      put(32'h40, 32'hb000_0000);
      tx_enable_bit_in <= 1'b0;
      kick();
      repeat (3) @(posedge clock_in);
      chk({31'h0, tx_kick_bit_out}, 32'h0);
      $display("test refused kick done");
   endtask

   task automatic give_verdict();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence after reset
   initial begin
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      tx_enable_bit_in <= 1'b1;
      repeat (8) @(posedge clock_in);
      t_full();
      t_half_ring();
      t_refuse();
      give_verdict();
   end
   // Watchdog, about 20000 cycles
   initial begin
      #2000000;
      err_total++;
      give_verdict();
   end
endmodule // test_etx_top
